// ===== include/ram_error_location_defs.vh
// Constants for the RAM error location record: register map, field layout, controls.
// Assumes inclusion by the core files only; holds definitions and nothing else.
`ifndef RAM_ERROR_LOCATION_DEFS_VH
`define RAM_ERROR_LOCATION_DEFS_VH
// Byte offsets of the 64-bit registers
`define LOC_OFFSET 12'h028
`define SPARE_A_OFFSET 12'h030
`define SPARE_B_OFFSET 12'h038
// Local control and status register (own map)
`define CTRL_OFFSET 12'h040
// Word offsets within a 64-bit register
`define WORD_LO 3'h0
`define WORD_HI 3'h4
// Location field positions
`define BITIDX_HI 59
`define BITIDX_LO 52
`define BITVAL_BIT 51
`define GRAN_HI 45
`define GRAN_LO 44
`define ROW_HI 35
`define ROW_LO 20
`define SUBP_HI 17
`define SUBP_LO 16
`define BANK_HI 12
`define BANK_LO 8
`define ARRAY_HI 3
`define ARRAY_LO 0
// Mask of implemented location bits; reserved bits read zero
`define LOC_IMPL_MASK 64'h0ff8_300f_fff3_1f0f
// Mask of location bits left writable under lock while injection allows it
`define INJ_WR_MASK 64'h0000_0000_0000_0000
// Array identifiers
`define ARR_L2_DATA 4'h8
`define ARR_L2_TAG 4'h9
`define ARR_L2_BUF 4'ha
`define ARR_DUP_TAG 4'hb
`define ARR_L2_TLB 4'hc
// Control register bits
`define CTRL_INJ_EN_BIT 0
`define CTRL_INJ_MV_BIT 1
`define CTRL_VALID_BIT 8
`define CTRL_INJECT_BIT 9
`define LOC_RESET 64'h0000_0000_0000_0000
`endif

// ===== core/apb_word_slave.v
// APB slave front end: single-cycle answer, decodes word writes and reads.
// Assumes an APB master on sys_clk; data mux comes from the parent.
`timescale 1ns/1ps
module apb_word_slave
(
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] rd_word,
  input wire rd_hit,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output wire wr_stb,
  output wire rd_stb
);
  // Access phase accepted this cycle (pready answers same access)
  assign wr_stb = psel & penable & pwrite & ~pready;
  assign rd_stb = psel & penable & ~pwrite & ~pready;
  //////////////////////////////////////////////////////////////////////////////
  // Answer one cycle into the access phase
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      if (psel & penable & ~pready)
      begin
        // Complete the transfer
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~rd_hit;
      end
      else
      begin
        // Idle or just completed
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule // apb_word_slave

// ===== core/loc_field_writer.v
// Merges a software word write into the location record.
// Assumes the parent provides the lock state and the writable mask.
`timescale 1ns/1ps
`include "ram_error_location_defs.vh"
module loc_field_writer
(
  input wire [63:0] cur,
  input wire [31:0] wdata,
  input wire hi_word,
  input wire locked,
  input wire [63:0] inj_mask,
  output reg [63:0] nxt
);
  reg [63:0] wide; // Write data at its word position
  reg [63:0] lane; // Word lane selected
  reg [63:0] wmask; // Bits the write may change
  //////////////////////////////////////////////////////////////////////////////
  // Combine lane, lock and reserved masks
  always @*
  begin
    wide = hi_word ? {wdata, 32'h0000_0000} : {32'h0000_0000, wdata};
    lane = hi_word ? 64'hffff_ffff_0000_0000 : 64'h0000_0000_ffff_ffff;
    wmask = locked ? (lane & inj_mask) : lane;
    wmask = wmask & `LOC_IMPL_MASK;
    nxt = (cur & ~wmask) | (wide & wmask);
  end
endmodule // loc_field_writer

// ===== core/ram_error_location_record.v
// RAM error location record: 64-bit location syndrome and two spare registers.
// Assumes an APB master on sys_clk and error capture logic on the same clock.
// Summary of operation
// - Location register at 0x28, 64 bits
// - Bits 59:52 hold error bit index
// - Bit 51 flags bit index valid
// - Bit index reads zero while invalid
// - Bits 45:44 hold protection granule
// - Bits 35:20 hold 16-bit row
// - Bits 17:16 hold sub-partition
// - Bits 12:8 hold bank
// - Bits 3:0 identify failing array
// - Fields read-only while syndrome valid set
// - Spare registers 0x30, 0x38 read zero
// - No accumulating syndrome held; nothing stays writable under lock
// - Injection leaves no field writable under lock (INJ_WR_MASK is zero)
// - Capture with injection enabled pulses injected_record
`timescale 1ns/1ps
`include "ram_error_location_defs.vh"
module ram_error_location_record
(
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  input wire cap_valid,
  input wire [3:0] cap_array,
  input wire [4:0] cap_bank,
  input wire [1:0] cap_sub_partition,
  input wire [15:0] cap_row,
  input wire [1:0] cap_granule,
  input wire cap_bit_index_valid,
  input wire [7:0] cap_error_bit_index,
  input wire misc_syndrome_valid,
  output reg injected_record
);
  //////////////////////////////////////////////////////////////////////////////
  // Storage
  reg [63:0] loc_q; // Location record
  reg [63:0] loc_d;
  reg [1:0] ctrl_q; // Injection enable, injection syndrome feature
  reg mv_sync_a_q; // Syndrome valid synchroniser stages
  reg mv_q;
  wire [63:0] loc_wr;
  wire wr_stb;
  reg [31:0] rd_word;
  reg rd_hit;
  wire hi_word;
  wire [63:0] loc_view;
  wire locked;
  wire inj_allow;
  assign hi_word = paddr[2];
  assign locked = mv_q;
  assign inj_allow = ctrl_q[`CTRL_INJ_EN_BIT] & ctrl_q[`CTRL_INJ_MV_BIT];
  //////////////////////////////////////////////////////////////////////////////
  // Address decode helper
  function is_reg;
    input [11:0] a;
    input [11:0] base;
    begin
      is_reg = (a[11:3] == base[11:3]) && (a[1:0] == 2'b00);
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Bus front end
  apb_word_slave u_bus
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .rd_word(rd_word),
    .rd_hit(rd_hit),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .wr_stb(wr_stb),
    .rd_stb()
  );
  //////////////////////////////////////////////////////////////////////////////
  // Software write merge
  loc_field_writer u_writer
  (
    .cur(loc_q),
    .wdata(pwdata),
    .hi_word(hi_word),
    .locked(locked),
    .inj_mask(inj_allow ? `INJ_WR_MASK : 64'h0000_0000_0000_0000),
    .nxt(loc_wr)
  );
  //////////////////////////////////////////////////////////////////////////////
  // Syndrome valid comes from the status block elsewhere; synchronise it
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mv_sync_a_q <= 1'b0;
      mv_q <= 1'b0;
    end
    else if (clk_en)
    begin
      mv_sync_a_q <= misc_syndrome_valid;
      mv_q <= mv_sync_a_q;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Next location value: capture wins over a software write
  always @*
  begin
    loc_d = loc_q;
    if (cap_valid && !locked)
    begin
      loc_d[`ARRAY_HI:`ARRAY_LO] = cap_array;
      loc_d[`BANK_HI:`BANK_LO] = cap_bank;
      loc_d[`SUBP_HI:`SUBP_LO] = cap_sub_partition;
      loc_d[`ROW_HI:`ROW_LO] = cap_row;
      loc_d[`GRAN_HI:`GRAN_LO] = cap_granule;
      loc_d[`BITVAL_BIT] = cap_bit_index_valid;
      loc_d[`BITIDX_HI:`BITIDX_LO] = cap_error_bit_index;
    end
    else if (wr_stb && is_reg(paddr, `LOC_OFFSET))
    begin
      loc_d = loc_wr;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Location and control registers
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loc_q <= `LOC_RESET;
      ctrl_q <= 2'b00;
      injected_record <= 1'b0;
    end
    else if (clk_en)
    begin
      loc_q <= loc_d;
      injected_record <= cap_valid & ~locked & ctrl_q[`CTRL_INJ_EN_BIT];
      if (wr_stb && is_reg(paddr, `CTRL_OFFSET) && !hi_word)
      begin
        ctrl_q <= {pwdata[`CTRL_INJ_MV_BIT], pwdata[`CTRL_INJ_EN_BIT]};
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Read view and read mux
  // Bit index hidden while invalid
  assign loc_view = loc_q[`BITVAL_BIT] ? (loc_q & `LOC_IMPL_MASK) :
                    (loc_q & `LOC_IMPL_MASK & 64'hf00f_ffff_ffff_ffff);
  always @*
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (is_reg(paddr, `LOC_OFFSET))
    begin
      rd_word = hi_word ? loc_view[63:32] : loc_view[31:0];
    end
    // Spare registers read zero, writes dropped
    else if (is_reg(paddr, `SPARE_A_OFFSET) || is_reg(paddr, `SPARE_B_OFFSET))
    begin
      rd_word = 32'h0000_0000;
    end
    else if (is_reg(paddr, `CTRL_OFFSET))
    begin
      if (!hi_word)
      begin
        rd_word[`CTRL_INJ_EN_BIT] = ctrl_q[`CTRL_INJ_EN_BIT];
        rd_word[`CTRL_INJ_MV_BIT] = ctrl_q[`CTRL_INJ_MV_BIT];
        rd_word[`CTRL_VALID_BIT] = mv_q;
        rd_word[`CTRL_INJECT_BIT] = injected_record;
      end
    end
    else
    begin
      // Unmapped address answers with an error
      rd_hit = 1'b0;
    end
  end
  // No accumulating counters live here; nothing else to keep writable
endmodule // ram_error_location_record

// ===== verification/ram_error_location_record_properties.sv
// Checker for the RAM error location record ports.
// Assumes the APB master of the bench; bound onto every record instance.
`timescale 1ns/1ps
module ram_error_location_record_properties
(
  input wire sys_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire injected_record
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Read answers by address window
  wire rd_ok = pready && !pwrite;
  wire unmapped = (paddr < 12'h028) || (paddr > 12'h047);
  ////////////////////////////////////////////////////////////////
  property p_ready_time; psel && penable && !pready |=> pready; endproperty
  a_ready_time: assert property (p_ready_time) else $error("late ready");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_ready_cause; pready |-> psel && penable; endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
  property p_unmapped; pready && unmapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped answer");
  property p_err_place; pslverr |-> pready && unmapped; endproperty
  a_err_place: assert property (p_err_place) else $error("stray error");
  property p_spare; rd_ok && paddr[11:4] == 8'h03 |-> prdata == 32'h0; endproperty
  a_spare: assert property (p_spare) else $error("spare not zero");
  property p_resv_lo; rd_ok && paddr == 12'h028 |-> (prdata & 32'h000c_e0f0) == 32'h0; endproperty
  a_resv_lo: assert property (p_resv_lo) else $error("reserved low set");
  property p_resv_hi; rd_ok && paddr == 12'h02c |-> (prdata & 32'hf007_cff0) == 32'h0; endproperty
  a_resv_hi: assert property (p_resv_hi) else $error("reserved high set");
  property p_idx_zero; rd_ok && paddr == 12'h02c && !prdata[19] |-> prdata[27:20] == 8'h0; endproperty
  a_idx_zero: assert property (p_idx_zero) else $error("index shown invalid");
  c_write: cover property (pready && pwrite);
  c_error: cover property (pslverr);
  c_inject: cover property (injected_record);
endmodule // ram_error_location_record_properties
bind ram_error_location_record ram_error_location_record_properties chk
(
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .injected_record(injected_record)
);

// ===== verification/ram_error_location_record_tb.sv
// Self-checking bench for the RAM error location record.
// Assumes the design header on the include path; clk_en drops once for a freeze test.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module ram_error_location_record_tb;
  logic sys_clk, sys_rst, psel, penable, pwrite, cap_valid, cap_bv, msv;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] cap_array;
  logic [4:0] cap_bank;
  logic [1:0] cap_sub, cap_gran;
  logic [15:0] cap_row;
  logic [7:0] cap_idx;
  logic pready, pslverr, injected_record, err, clk_en;
  logic inj_seen = 1'b0;
  logic [31:0] prdata;
  int n_mismatch = 0;
  int n_checks = 0;
  ram_error_location_record DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cap_valid(cap_valid),
    .cap_array(cap_array), .cap_bank(cap_bank), .cap_sub_partition(cap_sub),
    .cap_row(cap_row), .cap_granule(cap_gran), .cap_bit_index_valid(cap_bv),
    .cap_error_bit_index(cap_idx), .misc_syndrome_valid(msv),
    .injected_record(injected_record));
  initial
  begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Sticky flag for the injection pulse
  always @(posedge sys_clk) if (injected_record === 1'b1) inj_seen <= 1'b1;
  // One APB transfer, answer taken at the ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // Wait for ready; only the watchdog ends a hung transfer
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // One capture pulse with a fixed location pattern
  task cap(input logic [3:0] a);
    @(posedge sys_clk);
    cap_valid <= 1; cap_array <= a; cap_bank <= 5'h15; cap_sub <= 2'h2;
    cap_row <= 16'ha5c3; cap_gran <= 2'h1; cap_bv <= 1; cap_idx <= 8'h81;
    @(posedge sys_clk);
    cap_valid <= 0;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report;
  end
  initial
  begin
    sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; cap_valid = 0;
    cap_array = 0; cap_bank = 0; cap_sub = 0; cap_row = 0; cap_gran = 0; cap_bv = 0;
    cap_idx = 0; msv = 0; clk_en = 1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 0;
    apb(0, 12'h028, 0); `CHK("loc lo reset", 32'h0, rd)
    apb(1, 12'h028, 32'hffff_ffff); apb(0, 12'h028, 0);
    `CHK("loc lo ones", 32'hfff3_1f0f, rd)
    apb(1, 12'h02c, 32'hffff_ffff); apb(0, 12'h02c, 0);
    `CHK("loc hi ones", 32'h0ff8_300f, rd)
    apb(1, 12'h02c, 32'h0ff0_0000); apb(0, 12'h02c, 0);
    `CHK("idx hidden", 32'h0, rd)
    for (int i = 0; i < 4; i++)
    begin
      apb(1, 12'h030 + 4 * i, 32'hffff_ffff); apb(0, 12'h030 + 4 * i, 0);
      `CHK("spare", 32'h0, rd)
    end
    apb(0, 12'h100, 0); `CHK("unmapped err", 1'b1, err)
    $display("test register map done");
    for (int a = 8; a <= 12; a++)
    begin
      cap(a[3:0]); apb(0, 12'h028, 0);
      `CHK("cap lo", {12'h5c3, 4'h2, 3'h0, 5'h15, 4'h0, a[3:0]}, rd)
    end
    apb(0, 12'h02c, 0); `CHK("cap hi", 32'h0818_100a, rd)
    $display("test capture done");
    msv <= 1;
    repeat (4) @(posedge sys_clk);
    apb(1, 12'h028, 32'h0); cap(4'h8); apb(0, 12'h028, 0);
    `CHK("locked lo", 32'h5c32_150c, rd)
    apb(0, 12'h040, 0); `CHK("valid seen", 32'h0000_0100, rd)
    msv <= 0;
    repeat (4) @(posedge sys_clk);
    apb(1, 12'h028, 32'h0); apb(0, 12'h028, 0); `CHK("unlocked lo", 32'h0, rd)
    clk_en <= 0; cap(4'h9); clk_en <= 1;
    apb(0, 12'h028, 0); `CHK("frozen", 32'h0, rd)
    $display("test lock done");
    apb(1, 12'h040, 32'h3); cap(4'hb);
    repeat (4) @(posedge sys_clk);
    `CHK("injected", 1'b1, inj_seen)
    apb(0, 12'h040, 0); `CHK("ctrl rd", 32'h0000_0003, rd)
    $display("test injection done");
    final_report;
  end
endmodule // ram_error_location_record_tb
